// *** fdl_engine.v ***
// Design decision made here: the plain strobed port.
`include "fdl_engine_regs.vh"
module fdl_engine
#(
  parameter [3:0] QUALIFY_0 = 4'h1,
  parameter [3:0] QUALIFY_1 = 4'h2,
  parameter [3:0] QUALIFY_2 = 4'h3,
  parameter [3:0] QUALIFY_3 = 4'h4,
  parameter [3:0] DISINT_0 = 4'h2,
  parameter [3:0] DISINT_1 = 4'h4,
  parameter [3:0] DISINT_2 = 4'h8,
  parameter [3:0] DISINT_3 = 4'hf
)
(
  input wire i_clk_sys,
  input wire i_rst,
  input wire [8:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_tx_link_slot,
  input wire i_tx_serial_input,
  output reg o_tx_link_bit,
  input wire i_rx_link_slot,
  input wire i_rx_link_bit,
  input wire i_rx_multiframe,
  output wire o_interrupt_out_n
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] rx_code_control;
  reg [7:0] rx_link_byte;
  reg [5:0] rx_code_message;
  reg [2:0] rx_latched_status_seven;
  reg [2:0] rx_interrupt_mask_seven;
  reg [7:0] tx_link_control_two;
  reg [7:0] tx_link_byte;
  reg [5:0] tx_code_message;
  reg [7:0] tx_control_one;
  reg [7:0] tx_control_two;
  reg tx_latched_status_two;
  reg tx_interrupt_mask_two;
  reg [1:0] framer_mode;
  wire mode_e1 = framer_mode[`BIT_MODE_E1];
  wire mode_d4 = framer_mode[`BIT_MODE_D4];
  wire wr_rx_latched_status_seven = i_wr && i_addr == `ADDR_RX_LATCHED_STATUS_SEVEN;
  wire wr_tx_latched_status_two = i_wr && i_addr == `ADDR_TX_LATCHED_STATUS_TWO;
  wire wr_tx_byte = i_wr && i_addr == `ADDR_TX_LINK_BYTE;
  // ----------------------------------------
  // pin sampling: three stages, change when last two agree
  // ----------------------------------------
  reg [2:0] serial_sync;
  reg serial_level;
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      serial_sync <= 3'h0;
      serial_level <= 1'b0;
    end
    else
    begin
      serial_sync <= {serial_sync[1:0], i_tx_serial_input};
      if (serial_sync[2] == serial_sync[1])
        serial_level <= serial_sync[2];
    end
  end
  // ----------------------------------------
  // code transmit
  // ----------------------------------------
  wire send_code = tx_link_control_two[`BIT_SEND_CODE_ENABLE] && !mode_e1;
  wire code_bit;
  code_tx u_code_tx
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_bit_slot(i_tx_link_slot),
    .i_send(send_code),
    .i_code(tx_code_message),
    .o_bit(code_bit)
  );
  // ----------------------------------------
  // legacy transmit link byte
  // ----------------------------------------
  reg [7:0] tx_shift;
  reg [2:0] tx_count;
  reg tx_pending;
  wire [2:0] tx_last = mode_d4 ? 3'h5 : 3'h7;
  wire legacy_src = !tx_control_two[`BIT_TX_LINK_SOURCE_SELECT];
  reg tx_done;
  // byte reloads from register at each byte boundary: old value repeats if unwritten
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      tx_shift <= `RESET_BYTE;
      tx_count <= 3'h0;
      tx_pending <= 1'b0;
      tx_done <= 1'b0;
    end
    else
    begin
      tx_done <= 1'b0;
      if (wr_tx_byte)
        tx_pending <= 1'b1;
      if (i_tx_link_slot && legacy_src)
      begin
        if (tx_count == tx_last)
        begin
          tx_count <= 3'h0;
          tx_shift <= tx_link_byte;
          tx_done <= 1'b1;
          tx_pending <= wr_tx_byte;
        end
        else
        begin
          tx_count <= tx_count + 3'h1;
          tx_shift <= {1'b0, tx_shift[7:1]};
        end
      end
    end
  end
  // output mux: pass-through has priority over code, pass-through keeps serial framing bits
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
      o_tx_link_bit <= 1'b1;
    else if (i_tx_link_slot)
    begin
      if (tx_control_one[`BIT_FBIT_PASS_THROUGH])
        o_tx_link_bit <= serial_level;
      else if (send_code)
        o_tx_link_bit <= code_bit;
      else if (legacy_src)
        o_tx_link_bit <= tx_shift[0];
      else
        o_tx_link_bit <= serial_level;
    end
  end
  // ----------------------------------------
  // code receive and qualification
  // ----------------------------------------
  wire rx_valid;
  wire [5:0] rx_code;
  wire esf_rx = !mode_e1 && !mode_d4;
  code_rx u_code_rx
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_bit_slot(i_rx_link_slot && esf_rx),
    .i_bit(i_rx_link_bit),
    .o_valid(rx_valid),
    .o_code(rx_code)
  );
  function [3:0] pick;
    input [1:0] sel;
    input [3:0] a;
    input [3:0] b;
    input [3:0] c;
    input [3:0] d;
    begin
      case (sel)
        2'h0: pick = a;
        2'h1: pick = b;
        2'h2: pick = c;
        default: pick = d;
      endcase
    end
  endfunction
  wire [3:0] qualify_need = pick(rx_code_control[`BIT_QUALIFY_SEL0 +: 2], QUALIFY_0, QUALIFY_1,
    QUALIFY_2, QUALIFY_3);
  wire [3:0] disint_need = pick(rx_code_control[`BIT_DISINTEGRATE_SEL0 +: 2], DISINT_0, DISINT_1,
    DISINT_2, DISINT_3);
  reg [5:0] cand_code;
  reg [3:0] cand_count;
  reg [3:0] miss_count;
  reg [3:0] bit_count;
  reg code_held;
  reg set_detect;
  reg set_clear;
  // persistence counts whole codewords; miss counts codeword periods of sixteen bits
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      cand_code <= 6'h00;
      cand_count <= 4'h0;
      miss_count <= 4'h0;
      bit_count <= 4'h0;
      code_held <= 1'b0;
      set_detect <= 1'b0;
      set_clear <= 1'b0;
      rx_code_message <= 6'h00;
    end
    else
    begin
      set_detect <= 1'b0;
      set_clear <= 1'b0;
      if (rx_valid)
      begin
        bit_count <= 4'h0;
        miss_count <= 4'h0;
        if (rx_code == cand_code && cand_count != 4'h0)
        begin
          if (cand_count != 4'hf)
            cand_count <= cand_count + 4'h1;
        end
        else
        begin
          cand_code <= rx_code;
          cand_count <= 4'h1;
        end
        // a held code is reported once; a new code or a re-detect after clear reports again
        if ((rx_code == cand_code ? cand_count + 4'h1 : 4'h1) >= qualify_need &&
          (!code_held || rx_code != rx_code_message))
        begin
          set_detect <= 1'b1;
          rx_code_message <= rx_code;
          code_held <= 1'b1;
        end
      end
      else if (i_rx_link_slot && esf_rx)
      begin
        bit_count <= bit_count + 4'h1;
        if (bit_count == 4'hf)
        begin
          if (miss_count != 4'hf)
            miss_count <= miss_count + 4'h1;
          if (miss_count + 4'h1 == disint_need)
          begin
            cand_count <= 4'h0;
            if (code_held)
              set_clear <= 1'b1;
            code_held <= 1'b0;
          end
        end
      end
    end
  end
  // ----------------------------------------
  // legacy receive link byte
  // ----------------------------------------
  reg [7:0] rx_shift;
  reg [2:0] rx_count;
  reg rx_full;
  // D4 gathers Fs bits and publishes at multiframe; ESF publishes every eight bits
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      rx_shift <= `RESET_BYTE;
      rx_count <= 3'h0;
      rx_full <= 1'b0;
      rx_link_byte <= `RESET_BYTE;
    end
    else
    begin
      rx_full <= 1'b0;
      if (mode_d4 && i_rx_multiframe)
      begin
        rx_link_byte <= {2'b00, rx_shift[7:2]};
        rx_full <= 1'b1;
        rx_count <= 3'h0;
      end
      else if (i_rx_link_slot)
      begin
        rx_shift <= {i_rx_link_bit, rx_shift[7:1]};
        rx_count <= rx_count + 3'h1;
        if (rx_count == 3'h7 && !mode_d4)
        begin
          rx_link_byte <= {i_rx_link_bit, rx_shift[7:1]};
          rx_full <= 1'b1;
        end
      end
    end
  end
  // ----------------------------------------
  // register writes and sticky flags
  // ----------------------------------------
  // set wins over a write-one clear in the same cycle
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      rx_code_control <= `RESET_BYTE;
      rx_interrupt_mask_seven <= 3'h0;
      tx_link_control_two <= `RESET_BYTE;
      tx_link_byte <= `RESET_BYTE;
      tx_code_message <= 6'h00;
      tx_control_one <= `RESET_BYTE;
      tx_control_two <= `RESET_BYTE;
      tx_interrupt_mask_two <= 1'b0;
      framer_mode <= 2'h0;
      rx_latched_status_seven <= 3'h0;
      tx_latched_status_two <= 1'b0;
    end
    else
    begin
      if (i_wr)
      begin
        case (i_addr)
          `ADDR_RX_CODE_CONTROL: rx_code_control <= i_wdata;
          `ADDR_RX_INTERRUPT_MASK_SEVEN: rx_interrupt_mask_seven <= i_wdata[2:0];
          `ADDR_TX_LINK_CONTROL_TWO: tx_link_control_two <= i_wdata;
          `ADDR_TX_LINK_BYTE: tx_link_byte <= i_wdata;
          `ADDR_TX_CODE_MESSAGE: tx_code_message <= i_wdata[5:0];
          `ADDR_TX_CONTROL_ONE: tx_control_one <= i_wdata;
          `ADDR_TX_CONTROL_TWO: tx_control_two <= i_wdata;
          `ADDR_TX_INTERRUPT_MASK_TWO: tx_interrupt_mask_two <= i_wdata[`BIT_TX_LINK_EMPTY];
          `ADDR_FRAMER_MODE: framer_mode <= i_wdata[1:0];
          default: framer_mode <= framer_mode;
        endcase
      end
      rx_latched_status_seven <= (rx_latched_status_seven & ~(wr_rx_latched_status_seven ? i_wdata[2:0] : 3'h0)) |
        {rx_full, set_clear, set_detect};
      tx_latched_status_two <= (tx_latched_status_two & ~(wr_tx_latched_status_two && i_wdata[`BIT_TX_LINK_EMPTY])) |
        tx_done;
    end
  end
  assign o_interrupt_out_n = ~(|(rx_latched_status_seven & rx_interrupt_mask_seven) |
    (tx_latched_status_two & tx_interrupt_mask_two));
  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        `ADDR_RX_CODE_CONTROL: o_rdata <= rx_code_control;
        `ADDR_RX_LINK_BYTE: o_rdata <= rx_link_byte;
        `ADDR_RX_CODE_MESSAGE: o_rdata <= {2'b00, rx_code_message};
        `ADDR_RX_LATCHED_STATUS_SEVEN: o_rdata <= {5'h00, rx_latched_status_seven};
        `ADDR_RX_INTERRUPT_MASK_SEVEN: o_rdata <= {5'h00, rx_interrupt_mask_seven};
        `ADDR_TX_LINK_CONTROL_TWO: o_rdata <= tx_link_control_two;
        `ADDR_TX_LINK_BYTE: o_rdata <= tx_link_byte;
        `ADDR_TX_CODE_MESSAGE: o_rdata <= {2'b00, tx_code_message};
        `ADDR_TX_CONTROL_ONE: o_rdata <= tx_control_one;
        `ADDR_TX_CONTROL_TWO: o_rdata <= tx_control_two;
        `ADDR_TX_LATCHED_STATUS_TWO: o_rdata <= {3'h0, tx_latched_status_two, 4'h0};
        `ADDR_TX_INTERRUPT_MASK_TWO: o_rdata <= {3'h0, tx_interrupt_mask_two, 4'h0};
        `ADDR_FRAMER_MODE: o_rdata <= {6'h00, framer_mode};
        default: o_rdata <= 8'h00;
      endcase
    end
    else
      o_rdata <= 8'h00;
  end
endmodule // fdl_engine

// *** fdl_engine_regs.vh ***
`ifndef FDL_ENGINE_REGS_VH
`define FDL_ENGINE_REGS_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ADDR_RX_CODE_CONTROL 9'h015
`define ADDR_RX_LINK_BYTE 9'h062
`define ADDR_RX_CODE_MESSAGE 9'h063
`define ADDR_RX_LATCHED_STATUS_SEVEN 9'h096
`define ADDR_RX_INTERRUPT_MASK_SEVEN 9'h0a6
`define ADDR_TX_LINK_CONTROL_TWO 9'h113
`define ADDR_TX_LINK_BYTE 9'h162
`define ADDR_TX_CODE_MESSAGE 9'h163
`define ADDR_TX_CONTROL_ONE 9'h181
`define ADDR_TX_CONTROL_TWO 9'h182
`define ADDR_TX_LATCHED_STATUS_TWO 9'h191
`define ADDR_TX_INTERRUPT_MASK_TWO 9'h1a1
`define ADDR_FRAMER_MODE 9'h1f0
// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_SEND_CODE_ENABLE 6
`define BIT_FBIT_PASS_THROUGH 6
`define BIT_TX_LINK_SOURCE_SELECT 7
`define BIT_CODE_DETECTED_FLAG 0
`define BIT_CODE_CLEARED_FLAG 1
`define BIT_RX_LINK_FULL 2
`define BIT_TX_LINK_EMPTY 4
`define BIT_QUALIFY_SEL0 0
`define BIT_DISINTEGRATE_SEL0 2
`define BIT_MODE_E1 0
`define BIT_MODE_D4 1
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RESET_BYTE 8'h00
`define CODE_ABORT_PATTERN 8'hff
`define FRAME_TIME_NS 250000
`define CLOCK_PERIOD_NS 40
`endif

// *** code_tx.v ***
// ----------------------------------------
// code transmitter: 0 code 0 1111 1111 pattern, lsb first
// ----------------------------------------
module code_tx
(
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_bit_slot,
  input wire i_send,
  input wire [5:0] i_code,
  output reg o_bit
);
  reg [3:0] pos;
  reg active;
  // position 0 and 7 are zero, 1..6 code, 8..15 abort flag of ones
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      pos <= 4'h0;
      active <= 1'b0;
      o_bit <= 1'b1;
    end
    else if (i_bit_slot)
    begin
      if (!i_send)
      begin
        active <= 1'b0;
        pos <= 4'h0;
        o_bit <= 1'b1;
      end
      else
      begin
        active <= 1'b1;
        pos <= active ? pos + 4'h1 : 4'h1;
        if (!active || pos == 4'h0 || pos == 4'h7)
          o_bit <= 1'b0;
        else if (pos < 4'h7)
          o_bit <= i_code[pos[2:0] - 3'h1];
        else
          o_bit <= 1'b1;
      end
    end
  end
endmodule // code_tx

// *** code_rx.v ***
// ----------------------------------------
// code detector: finds 11111111 0 xxxxxx 0 pattern
// ----------------------------------------
`include "fdl_engine_regs.vh"
module code_rx
(
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_bit_slot,
  input wire i_bit,
  output reg o_valid,
  output reg [5:0] o_code
);
  reg [15:0] shift;
  wire [15:0] next_shift;
  assign next_shift = {i_bit, shift[15:1]};
  // newest bit at the top; a match means a whole codeword has just arrived
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      shift <= 16'h0000;
      o_valid <= 1'b0;
      o_code <= 6'h00;
    end
    else
    begin
      o_valid <= 1'b0;
      if (i_bit_slot)
      begin
        shift <= next_shift;
        if (next_shift[7:0] == `CODE_ABORT_PATTERN && !next_shift[8] && !next_shift[15] && next_shift[14:9] != 6'h3f)
        begin
          o_valid <= 1'b1;
          o_code <= next_shift[14:9];
        end
      end
    end
  end
endmodule // code_rx

// *** fdl_engine_chk.sv ***
// ------------------------------
// port checker
// ------------------------------
module fdl_engine_chk
(
  input wire i_clk_sys,
  input wire i_rst,
  input wire [8:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire i_tx_link_slot,
  input wire i_tx_serial_input,
  input wire o_tx_link_bit,
  input wire i_rx_link_slot,
  input wire i_rx_link_bit,
  input wire i_rx_multiframe,
  input wire o_interrupt_out_n
);
  timeunit 1ns;
  timeprecision 100ps;
  reg pt, send, src7, e1, txm, ser_q, slot_d;
  reg [2:0] rxm;
  reg [2:0] ser_cnt;
  reg [3:0] one_run;
  reg [3:0] zero_run;
  wire use_ser = pt || (src7 && (!send || e1));
  wire code_mode = send && !e1 && !pt;
  // shadow the control bits so line checks know the mode
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
      {pt, send, src7, e1, txm, rxm} <= 8'h00;
    else if (i_wr)
    begin
      case (i_addr)
        9'h181: pt <= i_wdata[6];
        9'h113: send <= i_wdata[6];
        9'h182: src7 <= i_wdata[7];
        9'h1f0: e1 <= i_wdata[0];
        9'h0a6: rxm <= i_wdata[2:0];
        9'h1a1: txm <= i_wdata[4];
        default: ;
      endcase
    end
  end
  // serial level age (input is resampled) and code bit run lengths
  always @(posedge i_clk_sys)
  begin
    ser_q <= i_tx_serial_input;
    slot_d <= i_tx_link_slot && code_mode;
    if (i_rst || ser_q != i_tx_serial_input)
      ser_cnt <= 3'h0;
    else if (ser_cnt != 3'h7)
      ser_cnt <= ser_cnt + 3'h1;
    if (i_rst || !code_mode)
    begin
      one_run <= 4'h0;
      zero_run <= 4'h0;
    end
    else if (slot_d)
    begin
      one_run <= o_tx_link_bit ? one_run + 4'h1 : 4'h0;
      zero_run <= o_tx_link_bit ? 4'h0 : zero_run + 4'h1;
    end
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  chk_reset_rest: assert property ($fell(i_rst) |-> o_tx_link_bit && o_interrupt_out_n && o_rdata == 8'h00)
    else $error("outputs not at rest after reset");
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  chk_unmapped_read: assert property ($past(i_rd) && $past(i_addr) == 9'h0ff |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_byte_readback: assert property ((i_wr && i_addr == 9'h162) ##1 (i_rd && i_addr == 9'h162)
    |=> o_rdata == $past(i_wdata, 2))
    else $error("link byte readback wrong");
  chk_serial_pass: assert property (use_ser && i_tx_link_slot && ser_cnt == 3'h7
    |=> o_tx_link_bit == $past(i_tx_serial_input))
    else $error("serial level not passed to line");
  chk_bit_hold: assert property (!i_tx_link_slot |=> $stable(o_tx_link_bit))
    else $error("line bit moved without a slot");
  chk_irq_masked: assert property (rxm == 3'h0 && !txm |-> o_interrupt_out_n)
    else $error("interrupt low with all masks off");
  chk_code_ones: assert property (code_mode |-> one_run <= 4'h8)
    else $error("code ones run too long");
  chk_code_zeros: assert property (code_mode |-> zero_run <= 4'h8)
    else $error("code zeros run too long");
  cov_code_send: cover property (code_mode && i_tx_link_slot);
  cov_irq_low: cover property (!o_interrupt_out_n);
  cov_readback: cover property ((i_wr && i_addr == 9'h162) ##1 i_rd);
endmodule // fdl_engine_chk
bind fdl_engine fdl_engine_chk chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_link_slot(i_tx_link_slot),
  .i_tx_serial_input(i_tx_serial_input), .o_tx_link_bit(o_tx_link_bit), .i_rx_link_slot(i_rx_link_slot),
  .i_rx_link_bit(i_rx_link_bit), .i_rx_multiframe(i_rx_multiframe), .o_interrupt_out_n(o_interrupt_out_n));

// *** line_model.sv ***
// ------------------------------
// line side: slots, rx bits, tx capture
// ------------------------------
module line_model
#(
  parameter int GAP = 12
)
(
  input logic i_clk_sys,
  input logic i_rst,
  input logic i_en,
  input logic [15:0] i_rx_word,
  input logic i_tx_bit,
  output logic o_slot,
  output logic o_rx_bit,
  output logic o_rx_mf,
  output logic [15:0] o_cap
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  logic [3:0] idx;
  logic [2:0] mf_cnt;
  logic slot_d;
  // frames shortened to GAP cycles; rx line toggles between slots as nobody holds it
  always @(posedge i_clk_sys)
  begin
    o_slot <= 1'b0;
    o_rx_mf <= 1'b0;
    o_rx_bit <= ~o_rx_bit;
    slot_d <= o_slot;
    if (slot_d)
      o_cap <= {i_tx_bit, o_cap[15:1]};
    if (i_rst)
    begin
      cnt <= 0;
      idx <= 4'h0;
      mf_cnt <= 3'h0;
      o_rx_bit <= 1'b0;
      o_cap <= 16'h0000;
    end
    else if (i_en)
    begin
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
      if (cnt == 0)
      begin
        o_slot <= 1'b1;
        o_rx_bit <= i_rx_word[idx];
        idx <= idx + 4'h1;
        mf_cnt <= (mf_cnt == 3'h5) ? 3'h0 : mf_cnt + 3'h1;
      end
      o_rx_mf <= cnt == 1 && mf_cnt == 3'h0;
    end
  end
endmodule // line_model

// *** fdl_engine_tb.sv ***
// ------------------------------
// bench
// ------------------------------
module fdl_engine_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ser = 1'b0;
  logic en = 1'b0;
  logic [15:0] rxw = 16'h0000;
  logic [7:0] rdata, v;
  logic slot, txb, rxb, mf, irq_n, hit;
  logic [15:0] cap;
  logic [31:0] tmp;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  // address, write data, value read back
  logic [24:0] rows [14] = '{{9'h015, 8'h0a, 8'h0a}, {9'h062, 8'h77, 8'h00}, {9'h063, 8'h11, 8'h00},
    {9'h096, 8'hff, 8'h00}, {9'h0a6, 8'h05, 8'h05}, {9'h113, 8'h00, 8'h00}, {9'h162, 8'ha5, 8'ha5},
    {9'h163, 8'h2d, 8'h2d}, {9'h181, 8'h00, 8'h00}, {9'h182, 8'h80, 8'h80}, {9'h191, 8'hff, 8'h00},
    {9'h1a1, 8'h10, 8'h10}, {9'h1f0, 8'h00, 8'h00}, {9'h0ff, 8'h5a, 8'h00}};
  fdl_engine uut (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_tx_link_slot(slot), .i_tx_serial_input(ser), .o_tx_link_bit(txb),
    .i_rx_link_slot(slot), .i_rx_link_bit(rxb), .i_rx_multiframe(mf), .o_interrupt_out_n(irq_n));
  line_model far (.i_clk_sys(clk), .i_rst(rst), .i_en(en), .i_rx_word(rxw), .i_tx_bit(txb),
    .o_slot(slot), .o_rx_bit(rxb), .o_rx_mf(mf), .o_cap(cap));
  // 25 MHz clock
  initial
  begin
    forever #20 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bus cycles, signals moved just after an edge
  task automatic wrt(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdt(input logic [8:0] a, output logic [7:0] q);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask
  // write then read with no gap
  task automatic wrd(input logic [8:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask
  // poll a status bit, bounded
  task automatic wait_bit(input logic [8:0] a, input int b);
    logic [7:0] q;
    int n;
    q = 8'h00;
    n = 0;
    while (q[b] !== 1'b1 && n < 2000)
    begin
      rdt(a, q);
      n++;
    end
    chk(q[b], 1'b1);
  endtask
  task automatic slots(input int n);
    repeat (n * 12) @(posedge clk);
  endtask
  // clear the empty flag and wait for the next byte to go out
  task automatic next_empty();
    wrt(9'h191, 8'h10);
    #1;
    chk(irq_n, 1'b1);
    wait_bit(9'h191, 4);
    chk(irq_n, 1'b0);
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      bad_count++;
      end_sim();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      rdt(rows[i][24:16], v);
      chk(v, 8'h00);
      wrd(rows[i][24:16], rows[i][15:8], v);
      chk(v, rows[i][7:0]);
    end
    $display("register table done");
    wrt(9'h0a6, 8'h00);
    wrt(9'h182, 8'h00);
    wrt(9'h162, 8'hb4);
    en <= 1'b1;
    next_empty();
    repeat (2)
    begin
      next_empty();
      chk(cap[15:8], 8'hb4);
    end
    $display("transmit byte done");
    wrt(9'h1f0, 8'h02);
    wrt(9'h162, 8'h1c);
    next_empty();
    repeat (2)
    begin
      next_empty();
      chk(cap[15:10], 6'h1c);
    end
    wrt(9'h096, 8'h04);
    wait_bit(9'h096, 2);
    rdt(9'h062, v);
    chk(v[7:6], 2'h0);
    $display("d4 byte done");
    wrt(9'h1f0, 8'h00);
    wrt(9'h163, 8'h2d);
    wrt(9'h113, 8'h40);
    slots(36);
    hit = 1'b0;
    for (int k = 0; k < 16; k++)
    begin
      tmp = {cap, cap} >> k;
      if (tmp[15:0] == {8'hff, 1'b0, 6'h2d, 1'b0})
        hit = 1'b1;
    end
    chk(hit, 1'b1);
    wrt(9'h182, 8'h80);
    wrt(9'h1f0, 8'h01);
    slots(20);
    chk(cap, 16'h0000);
    ser <= 1'b1;
    wrt(9'h1f0, 8'h00);
    wrt(9'h181, 8'h40);
    slots(20);
    chk(cap, 16'hffff);
    wrt(9'h181, 8'h00);
    wrt(9'h113, 8'h00);
    $display("transmit code done");
    wrt(9'h1a1, 8'h00);
    wrt(9'h0a6, 8'h07);
    wrt(9'h015, 8'h00);
    wrt(9'h096, 8'h07);
    rxw <= {1'b0, 6'h15, 1'b0, 8'hff};
    wait_bit(9'h096, 0);
    chk(irq_n, 1'b0);
    rdt(9'h063, v);
    chk(v, 8'h15);
    wait_bit(9'h096, 2);
    rdt(9'h062, v);
    // byte boundaries are not tied to the word start, so any eight-bit window of the stream counts
    hit = 1'b0;
    for (int k = 0; k < 16; k++)
    begin
      tmp = {rxw, rxw} >> k;
      if (tmp[7:0] == v)
        hit = 1'b1;
    end
    chk(hit, 1'b1);
    wrt(9'h096, 8'h03);
    slots(48);
    rdt(9'h096, v);
    chk(v[1:0], 2'h0);
    rxw <= 16'h0000;
    wait_bit(9'h096, 1);
    rxw <= {1'b0, 6'h15, 1'b0, 8'hff};
    wait_bit(9'h096, 0);
    $display("receive code done");
    end_sim();
  end
endmodule // fdl_engine_tb
